/* File: logic/pll_synth_consts.vh */
// Purpose: Shared constants of the phase-tap clock synthesizer
// Assumes: Included by the synthesizer top and the port monitor by bare name
// Notes: Offsets are byte addresses on the AXI4-Lite slave; the counter base is the upper address nibble
`ifndef PLL_SYNTH_CONSTS_VH
`define PLL_SYNTH_CONSTS_VH

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_CNT_BASE 4'h1

`define CTRL_RESET 32'h0010_0101
`define CTRL_MASK 32'h0117_3f3f
`define CTRL_DIV_LSB 0
`define CTRL_MULT_LSB 8
`define CTRL_FBTAP_LSB 16
`define CTRL_INTFB_BIT 20
`define CTRL_HOLD_BIT 24

`define CNT_RESET 32'h0000_0002
`define CNT_MASK 32'h3f07_ffff
`define CNT_DIV_LSB 0
`define CNT_HIGH_LSB 8
`define CNT_TAP_LSB 16
`define CNT_DLY_LSB 24

`define DIV_MIN 6'd1
`define DIV_MAX 6'd52
`define TAP_HALF 3'd4
`define LOCK_GOOD 3'd4

`define CLOCK_MHZ 10
`define LOSS_TIME_US 100
`define LOSS_CYCLES (`LOSS_TIME_US * `CLOCK_MHZ)

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: logic/output_divider.v */
// Purpose: One programmable output counter clocked by half-period steps of one phase tap
// Assumes: step pulses once per half oscillator period of the chosen tap
// Notes: Divide 0 acts as 1, high count 0 gives half duty
`timescale 1ns/100ps
module output_divider (
  input wire clock,
  input wire reset_n,
  input wire run,
  input wire step,
  input wire [7:0] divide,
  input wire [7:0] high_halves,
  input wire [5:0] delay,
  output wire clock_out
);

  reg [6:0] elapsed_q;
  reg [8:0] cnt_q;
  reg out_q;
  wire [7:0] div_eff;
  wire [8:0] span;
  wire [8:0] high_eff;
  wire active;

  assign div_eff = (divide == 8'h00) ? 8'h01 : divide;
  // Counting in half periods gives odd ratios a balanced duty
  assign span = {div_eff, 1'b0};
  assign high_eff = (high_halves == 8'h00) ? {1'b0, div_eff} : {1'b0, high_halves};
  // Whole-cycle delay is two half steps per oscillator cycle
  assign active = (elapsed_q >= {delay, 1'b0});
  assign clock_out = out_q;

  always @(posedge clock) begin
    if (!reset_n || !run) begin
      elapsed_q <= 7'h00;
      cnt_q <= 9'h000;
      out_q <= 1'b0;
    end else if (step) begin
      if (!active) begin
        elapsed_q <= elapsed_q + 7'h01;
      end else begin
        out_q <= (cnt_q < high_eff);
        cnt_q <= (cnt_q == span - 9'h001) ? 9'h000 : cnt_q + 9'h001;
      end
    end
  end

endmodule

/* File: logic/pll_phase_tap_clock_synth.v */
// Purpose: Digital model of a phase-locked clock synthesizer with eight oscillator taps
// Assumes: Oscillator period is eight clock cycles; reference inputs are synchronous samples
// Notes: Registers over AXI4-Lite; one write and one read outstanding
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "pll_synth_consts.vh"
module pll_phase_tap_clock_synth (
  input wire clock,
  input wire reset_n,
  input wire ref_clock_primary,
  input wire ref_clock_alternate,
  input wire ref_clock_select,
  input wire feedback_clock_in,
  output wire output_counter_zero,
  output wire output_counter_one,
  output wire output_counter_two,
  output wire output_counter_three,
  output wire feedback_clock_out,
  output wire locked,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  function [5:0] clamp_ratio;
    input [5:0] v;
    clamp_ratio = (v < `DIV_MIN) ? `DIV_MIN : ((v > `DIV_MAX) ? `DIV_MAX : v);
  endfunction
  // Rising and falling edges of a tap, as positions of the oscillator phase
  function half_step;
    input [2:0] pos;
    input [2:0] tap;
    half_step = (pos == tap) || (pos == (tap ^ `TAP_HALF));
  endfunction
  function [31:0] merge_strb;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge_strb = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge_strb[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction
  function is_mapped;
    input [7:0] addr;
    begin
      if (addr == `ADDR_CTRL) begin
        is_mapped = 1'b1;
      end else if (addr == `ADDR_STATUS) begin
        is_mapped = 1'b1;
      end else if (addr[7:4] == `ADDR_CNT_BASE && addr[1:0] == 2'b00) begin
        is_mapped = 1'b1;
      end else begin
        is_mapped = 1'b0;
      end
    end
  endfunction
  // Register state
  reg [31:0] ctrl_q;
  reg [31:0] cnt_cfg_q [0:3];
  // AXI4-Lite slave state
  reg aw_held_q;
  reg [7:0] awaddr_q;
  reg w_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_d;

  // Synthesizer state
  reg [2:0] pos_q;
  reg [7:0] tap_q;
  reg ref_prev_q;
  reg [5:0] in_cnt_q;
  reg fb_prev_q;
  reg fbin_prev_q;
  reg [1:0] fb_seen_q;
  reg [2:0] good_q;
  reg [9:0] ref_idle_q;
  reg [9:0] fb_idle_q;
  reg ref_lost_q;
  reg fb_lost_q;
  reg [4:0] started_q;
  wire aw_take;
  wire w_take;
  wire aw_have;
  wire w_have;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire do_write;
  wire ar_take;
  wire run;
  wire [5:0] in_ratio;
  wire [5:0] fb_mult;
  wire [2:0] fb_tap;
  wire internal_fb;
  wire ref_mux;
  wire ref_edge;
  wire pfd_ref;
  wire fb_int;
  wire fb_edge;
  wire [3:0] outs;
  wire [4:0] start_now;
  integer i;
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign aw_have = aw_held_q | aw_take;
  assign w_have = w_held_q | w_take;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  assign do_write = aw_have & w_have & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always @(posedge clock) begin
    if (!reset_n) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      ctrl_q <= `CTRL_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        cnt_cfg_q[i] <= `CNT_RESET;
      end
    end else begin
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_addr == `ADDR_CTRL) begin
          ctrl_q <= merge_strb(ctrl_q, wr_data, wr_strb) & `CTRL_MASK;
        end else if (wr_addr[7:4] == `ADDR_CNT_BASE && wr_addr[1:0] == 2'b00) begin
          cnt_cfg_q[wr_addr[3:2]] <= merge_strb(cnt_cfg_q[wr_addr[3:2]], wr_data, wr_strb) & `CNT_MASK;
        end
      end else begin
        if (aw_take) begin
          aw_held_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    if (s_axi_araddr == `ADDR_CTRL) begin
      rdata_d = ctrl_q;
    end else if (s_axi_araddr == `ADDR_STATUS) begin
      rdata_d = {11'h000, tap_q, feedback_clock_out, outs, 4'h0, ref_clock_select, fb_lost_q, ref_lost_q, locked};
    end else if (s_axi_araddr[7:4] == `ADDR_CNT_BASE && s_axi_araddr[1:0] == 2'b00) begin
      rdata_d = cnt_cfg_q[s_axi_araddr[3:2]];
    end
  end

  always @(posedge clock) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Software hold acts like reset on the synthesizer only
  assign run = ~ctrl_q[`CTRL_HOLD_BIT];
  assign in_ratio = clamp_ratio(ctrl_q[`CTRL_DIV_LSB +: 6]);
  assign fb_mult = ctrl_q[`CTRL_MULT_LSB +: 6];
  assign fb_tap = ctrl_q[`CTRL_FBTAP_LSB +: 3];
  assign internal_fb = ctrl_q[`CTRL_INTFB_BIT];

  // Oscillator: one phase position drives all taps, so their order is fixed
  always @(posedge clock) begin
    if (!reset_n || !run) begin
      pos_q <= 3'd0;
      tap_q <= 8'h00;
      started_q <= 5'h00;
    end else begin
      pos_q <= pos_q + 3'd1;
      started_q <= started_q | start_now;
      for (i = 0; i < 8; i = i + 1) begin
        tap_q[i] <= ((pos_q - i[2:0]) < `TAP_HALF);
      end
    end
  end

  // Select reaches the mux with no synchronizer; glitches pass through
  assign ref_mux = ref_clock_select ? ref_clock_alternate : ref_clock_primary;
  // The controller keeps the block in reset across a select change
  assign ref_edge = ref_mux & ~ref_prev_q;
  assign pfd_ref = ref_edge && (in_cnt_q == in_ratio - 6'd1);
  assign fb_edge = internal_fb ? (fb_int & ~fb_prev_q) : (feedback_clock_in & ~fbin_prev_q);

  always @(posedge clock) begin
    if (!reset_n || !run) begin
      ref_prev_q <= 1'b0;
      in_cnt_q <= 6'd0;
      fb_prev_q <= 1'b0;
      fbin_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_mux;
      fb_prev_q <= fb_int;
      fbin_prev_q <= feedback_clock_in;
      if (ref_edge) begin
        in_cnt_q <= (in_cnt_q >= in_ratio - 6'd1) ? 6'd0 : in_cnt_q + 6'd1;
      end
    end
  end

  // Lock: exactly one feedback edge per divided reference edge, several in a row
  always @(posedge clock) begin
    if (!reset_n || !run) begin
      fb_seen_q <= 2'd0;
      good_q <= 3'd0;
    end else begin
      if (pfd_ref) begin
        fb_seen_q <= fb_edge ? 2'd1 : 2'd0;
        if ((fb_seen_q == 2'd1) && !ref_lost_q && !fb_lost_q) begin
          good_q <= (good_q == `LOCK_GOOD) ? good_q : good_q + 3'd1;
        end else begin
          good_q <= 3'd0;
        end
      end else if (fb_edge && fb_seen_q != 2'd2) begin
        fb_seen_q <= fb_seen_q + 2'd1;
      end
      if (ref_lost_q || fb_lost_q) begin
        good_q <= 3'd0;
      end
    end
  end

  // Missing input or feedback drops lock; outputs then cannot be trusted
  always @(posedge clock) begin
    if (!reset_n || !run) begin
      ref_idle_q <= 10'd0;
      fb_idle_q <= 10'd0;
      ref_lost_q <= 1'b0;
      fb_lost_q <= 1'b0;
    end else begin
      if (ref_edge) begin
        ref_idle_q <= 10'd0;
        ref_lost_q <= 1'b0;
      end else if (ref_idle_q == `LOSS_CYCLES - 1) begin
        ref_lost_q <= 1'b1;
      end else begin
        ref_idle_q <= ref_idle_q + 10'd1;
      end
      if (fb_edge) begin
        fb_idle_q <= 10'd0;
        fb_lost_q <= 1'b0;
      end else if (fb_idle_q == `LOSS_CYCLES - 1) begin
        fb_lost_q <= 1'b1;
      end else begin
        fb_idle_q <= fb_idle_q + 10'd1;
      end
    end
  end
  assign locked = (good_q == `LOCK_GOOD) && !ref_lost_q && !fb_lost_q;
  // A counter starts on its own tap's rise, never its fall, so a half-period tap really lags
  assign start_now[4] = (pos_q == fb_tap);
  // Feedback counter divides the oscillator by the multiplier on its own tap
  output_divider fb_counter (
    .clock(clock),
    .reset_n(reset_n),
    .run(run & (started_q[4] | start_now[4])),
    .step(half_step(pos_q, fb_tap)),
    .divide({2'b00, fb_mult}),
    .high_halves(8'h00),
    .delay(6'd0),
    .clock_out(fb_int)
  );

  assign feedback_clock_out = fb_int;

  // Output taps are referred to the feedback tap, so a feedback offset moves them earlier
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : out_ctr
      wire [2:0] eff_tap;
      assign eff_tap = cnt_cfg_q[g][`CNT_TAP_LSB +: 3] - fb_tap;
      assign start_now[g] = (pos_q == eff_tap);
      output_divider counter (
        .clock(clock),
        .reset_n(reset_n),
        .run(run & (started_q[g] | start_now[g])),
        .step(half_step(pos_q, eff_tap)),
        .divide(cnt_cfg_q[g][`CNT_DIV_LSB +: 8]),
        .high_halves(cnt_cfg_q[g][`CNT_HIGH_LSB +: 8]),
        .delay(cnt_cfg_q[g][`CNT_DLY_LSB +: 6]),
        .clock_out(outs[g])
      );
    end
  endgenerate

  // Ratios count oscillator edges only, so phases stay relative to its period
  assign output_counter_zero = outs[0];
  assign output_counter_one = outs[1];
  assign output_counter_two = outs[2];
  // Cascading feeds one output into another block's reference input
  assign output_counter_three = outs[3];

endmodule

/* File: testbench/ref_clock_source.sv */
// Purpose: Reference clock sources feeding the synthesizer inputs
// Assumes: Half period counted in system clock cycles
// Notes: A stopped source stands still low
`timescale 1ns/100ps
module ref_clock_source #(
  parameter int HALF = 4
) (
  input wire clock,
  input wire run_primary,
  input wire run_alternate,
  output logic ref_clock_primary = 1'b0,
  output logic ref_clock_alternate = 1'b0
);
  int count_q = 0;
  // Rate matches oscillator over feedback multiplier at the default settings
  always @(posedge clock) begin
    count_q <= (count_q == HALF - 1) ? 0 : count_q + 1;
    if (count_q == HALF - 1) begin
      ref_clock_primary <= run_primary ? !ref_clock_primary : 1'b0;
      ref_clock_alternate <= run_alternate ? !ref_clock_alternate : 1'b0;
    end
  end
endmodule

/* File: testbench/synth_monitor.sv */
// Purpose: Port checks of the clock synthesizer
// Assumes: Counters hold their default settings after every reset
// Notes: Bound to the top module
`timescale 1ns/100ps
`include "pll_synth_consts.vh"
module synth_monitor (
  input wire clock,
  input wire reset_n,
  input wire output_counter_zero,
  input wire output_counter_one,
  input wire output_counter_two,
  input wire output_counter_three,
  input wire locked,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [3:0] outs = {output_counter_three, output_counter_two, output_counter_one, output_counter_zero};
  function automatic logic unmapped(input logic [7:0] a);
    return !(a == 8'h00 || a == 8'h04 || (a[7:4] == 4'h1 && a[1:0] == 2'b00));
  endfunction
  // Taps form one ring of four adjacent high taps, so their order cannot change
  function automatic logic tap_ring(input logic [7:0] t);
    return t == 8'h00 || ($countones(t) == 4 && $countones(t ^ {t[6:0], t[7]}) == 2);
  endfunction
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_reset_quiet;
    disable iff (1'b0) !reset_n |=> outs == 4'h0 && !locked && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_restart_together;
    $rose(reset_n) |-> (outs == 4'h0 || outs == 4'hf) [*8];
  endproperty
  property p_write_answer;
    s_w_take |=> s_axi_bvalid;
  endproperty
  property p_read_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_read_resp;
    s_ar_take |=> s_axi_rresp == (unmapped($past(s_axi_araddr)) ? `RESP_SLVERR : `RESP_OKAY);
  endproperty
  property p_tap_order;
    s_ar_take ##0 (s_axi_araddr == 8'h04) |=> tap_ring(s_axi_rdata[20:13]);
  endproperty
  property p_unmapped_data;
    s_ar_take ##0 unmapped(s_axi_araddr) |=> s_axi_rdata == 32'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active during reset");
  a_restart_together: assert property (p_restart_together) else $error("outputs not in step");
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  a_read_answer: assert property (p_read_answer) else $error("read response late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  a_w_refuse: assert property (p_w_refuse) else $error("write taken while busy");
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
  a_read_resp: assert property (p_read_resp) else $error("read response code wrong");
  a_unmapped_data: assert property (p_unmapped_data) else $error("unmapped read data not zero");
  a_tap_order: assert property (p_tap_order) else $error("oscillator tap order broken");
endmodule
bind pll_phase_tap_clock_synth synth_monitor mon (.*);

/* File: testbench/pll_phase_tap_clock_synth_bench.sv */
// Purpose: Self-checking bench of the clock synthesizer
// Assumes: Feedback output looped to feedback input
// Notes: Output phases measured after reset or hold release
`timescale 1ns/100ps
module pll_phase_tap_clock_synth_bench;
  logic clock = 0, reset_n = 0, ref_clock_select = 0, run_primary = 1, run_alternate = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire output_counter_zero, output_counter_one, output_counter_two, output_counter_three;
  wire feedback_clock_out, locked, ref_clock_primary, ref_clock_alternate;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire feedback_clock_in = feedback_clock_out;
  wire [3:0] outs = {output_counter_three, output_counter_two, output_counter_one, output_counter_zero};
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  int rise1[4], rise2[4];
  always #50 clock = ~clock;
  pll_phase_tap_clock_synth uut (.*);
  ref_clock_source src (.*);
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aok = 0, wok = 0, got;
    logic [1:0] r;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    do begin
      @(negedge clock);
      got = !aok && s_axi_awready; aok |= s_axi_awready; wok |= s_axi_wready;
      @(posedge clock);
      if (aok) s_axi_awvalid <= 0;
      if (wok) s_axi_wvalid <= 0;
    end while (!(aok && wok));
    s_axi_bready <= 1;
    do begin @(negedge clock); got = s_axi_bvalid; r = s_axi_bresp; @(posedge clock); end while (!got);
    s_axi_bready <= 0;
    chk("bresp", er, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0] r;
    logic got;
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do begin @(negedge clock); got = s_axi_arready; @(posedge clock); end while (!got);
    s_axi_arvalid <= 0; s_axi_rready <= 1;
    do begin @(negedge clock); got = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp; @(posedge clock); end while (!got);
    s_axi_rready <= 0;
    chk("rresp", er, r);
    chk("rdata", e, d & m);
  endtask
  task automatic measure;
    logic [3:0] prev = 0;
    for (int i = 0; i < 4; i++) begin rise1[i] = -100; rise2[i] = -100; end
    for (int k = 0; k < 64; k++) begin
      @(negedge clock);
      for (int i = 0; i < 4; i++)
        if (outs[i] && !prev[i]) begin
          if (rise1[i] < 0) rise1[i] = k; else if (rise2[i] < 0) rise2[i] = k;
        end
      prev = outs;
    end
    @(posedge clock);
  endtask
  function automatic int gap(int i, int j, int p);
    return ((rise1[j] - rise1[i]) % p + p) % p;
  endfunction
  // Reprogram under hold so no output glitches, then release and measure
  task automatic reprogram(input logic [31:0] ctrl, c0, c1, c2, c3);
    wr(8'h00, ctrl | 32'h0100_0000, 2'b00);
    wr(8'h10, c0, 2'b00); wr(8'h14, c1, 2'b00); wr(8'h18, c2, 2'b00); wr(8'h1c, c3, 2'b00);
    wr(8'h00, ctrl, 2'b00);
    measure();
  endtask
  task automatic wait_lock(input logic e);
    for (int k = 0; k < 1500; k++) begin
      @(negedge clock);
      if (locked === e) break;
    end
    chk("locked", e, locked);
    @(posedge clock);
  endtask
  task t_defaults;
    measure();
    chk("period0", 16, rise2[0] - rise1[0]);
    for (int i = 1; i < 4; i++) chk("start gap", 0, gap(0, i, 16));
    rd(8'h00, 2'b00, 32'hffff_ffff, 32'h0010_0101);
    for (int i = 0; i < 4; i++) rd(8'h10 + 8'(4 * i), 2'b00, 32'hffff_ffff, 32'h2);
    rd(8'h20, 2'b10, 32'hffff_ffff, 32'h0);
    rd(8'h08, 2'b10, 32'hffff_ffff, 32'h0);
    wr(8'h40, 32'h1, 2'b10);
    wr(8'h04, 32'hffff_ffff, 2'b00);
    rd(8'h00, 2'b00, 32'hffff_ffff, 32'h0010_0101);
    wr(8'h00, 32'h0000_3434, 2'b00);
    rd(8'h00, 2'b00, 32'h0000_003f, 32'h34);
  endtask
  task t_taps;
    reprogram(32'h0010_0101, 32'h2, 32'h0004_0002, 32'h3, 32'h0100_0003);
    chk("period0", 16, rise2[0] - rise1[0]);
    chk("half shift", 4, gap(0, 1, 16));
    chk("period2", 24, rise2[2] - rise1[2]);
    chk("period3", 24, rise2[3] - rise1[3]);
    chk("cycle delay", 8, gap(2, 3, 24));
  endtask
  task t_offset;
    reprogram(32'h0012_0101, 32'h2, 32'h0002_0002, 32'h2, 32'h2);
    chk("fb shift", 6, gap(1, 0, 16));
    chk("relative", 0, gap(0, 2, 16));
    chk("relative", 0, gap(0, 3, 16));
  endtask
  task t_lock;
    wr(8'h00, 32'h0010_0101, 2'b00);
    wait_lock(1);
    wr(8'h00, 32'h0000_0202, 2'b00);
    wait_lock(1);
    run_primary <= 0;
    wait_lock(0);
    rd(8'h04, 2'b00, 32'h2, 32'h2);
    reset_n <= 0;
    @(posedge clock);
    ref_clock_select <= 1;
    repeat (4) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    rd(8'h04, 2'b00, 32'h8, 32'h8);
    wait_lock(1);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    t_defaults;
    t_taps;
    t_offset;
    t_lock;
    final_report;
  end
endmodule
